/* core/buck_fault_protection_hiccup.sv */
// Purpose: overcurrent hiccup, over-voltage and thermal latch-off for two channels
// Assumes: comparator inputs synchronous to I_MCLK; I_CYCLE pulses once per switching cycle
// Notes:   I_RSTN is the power-on reset; outputs are all registered
`timescale 1ns/100ps
module buck_fault_protection_hiccup #(
  parameter int SS_CYCLES   = fault_prot_pkg::SS_CYCLES,
  parameter int STEP_CYCLES = fault_prot_pkg::STEP_CYCLES
) (
  input  wire logic                               I_MCLK,
  input  wire logic                               I_RSTN,
  input  wire logic                               I_CYCLE,
  input  wire logic                               I_ENABLE,
  input  wire logic                               I_CURRENT_CONFIG_SELECT_A,
  input  wire logic                               I_CURRENT_CONFIG_SELECT_B,
  input  wire fault_prot_pkg::chan_sense_s        I_SENSE_1,
  input  wire fault_prot_pkg::chan_sense_s        I_SENSE_2,
  input  wire logic                               I_OVER_TEMP,
  output logic                                    O_CHAN_ON,
  output logic [fault_prot_pkg::REF_W-1:0]        O_SS_REF,
  output logic [1:0]                              O_OVER_CURRENT,
  output logic                                    O_OUTPUT_IN_WINDOW_1,
  output logic                                    O_OUTPUT_IN_WINDOW_2,
  output logic                                    O_THERMAL_LATCHED
);
  // decode the select pair into slave counts per channel
  function automatic fault_prot_pkg::block_cfg_s decode_cfg(input logic [1:0] sel);
    fault_prot_pkg::block_cfg_s c;
    case (sel)
      2'b00:   c = '{slaves_a: 3'h2, slaves_b: 3'h2};
      2'b01:   c = '{slaves_a: 3'h3, slaves_b: 3'h1};
      2'b10:   c = '{slaves_a: 3'h1, slaves_b: 3'h3};
      default: c = '{slaves_a: 3'h4, slaves_b: 3'h0};
    endcase
    return c;
  endfunction

  // limit in amps: base of the master block plus 2A per slave
  function automatic logic [fault_prot_pkg::LIM_W-1:0] oc_limit(input logic [2:0] slaves);
    return fault_prot_pkg::LIM_BASE_A + 5'(slaves) * fault_prot_pkg::LIM_STEP_A;
  endfunction

  fault_prot_pkg::block_cfg_s    cfg_q, cfg_d;
  logic                          cfg_taken_q, cfg_taken_d;
  logic [fault_prot_pkg::LIM_W-1:0] lim_1, lim_2;
  logic [1:0]                    over_now;
  logic [1:0]                    oc_q, oc_d;
  logic                          oc_full;
  logic                          cnt_clear;
  logic [fault_prot_pkg::CNT_W-1:0] oc_count;
  fault_prot_pkg::prot_state_e   st_q, st_d;
  logic [31:0]                   tmr_q, tmr_d;
  logic [31:0]                   step_q, step_d;
  logic [fault_prot_pkg::REF_W-1:0] ref_q, ref_d;
  logic                          therm_q, therm_d;
  logic [1:0]                    ov_q, ov_d;
  logic [1:0]                    win_q, win_d;
  logic                          on_q, on_d;

  // capture the configuration once after power-on reset release
  always_comb begin
    cfg_taken_d = 1'b1;
    cfg_d       = cfg_taken_q ? cfg_q
                  : decode_cfg({I_CURRENT_CONFIG_SELECT_B, I_CURRENT_CONFIG_SELECT_A});
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cfg_taken_q <= 1'b0;
      cfg_q       <= '{slaves_a: 3'h0, slaves_b: 3'h0};
    end else begin
      cfg_taken_q <= cfg_taken_d;
      cfg_q       <= cfg_d;
    end
  end

  // per-channel comparison, sampled once each switching cycle
  assign lim_1    = oc_limit(cfg_q.slaves_a);
  assign lim_2    = oc_limit(cfg_q.slaves_b);
  assign over_now = {I_SENSE_2.current_a > lim_2, I_SENSE_1.current_a > lim_1};

  always_comb begin
    oc_d = (I_CYCLE && on_q) ? over_now : oc_q;
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      oc_q <= 2'b00;
    end else begin
      oc_q <= oc_d;
    end
  end

  // shared counter, cleared on entering cool-down
  assign cnt_clear = (st_q != fault_prot_pkg::ST_COOL) && (st_d == fault_prot_pkg::ST_COOL);

  oc_counter u_oc_counter (
    .i_clk    (I_MCLK),
    .i_rst_n  (I_RSTN),
    .i_sample (I_CYCLE && on_q),
    .i_over   (over_now),
    .i_clear  (cnt_clear),
    .o_count  (oc_count),
    .o_full   (oc_full)
  );

  // thermal latch: set by over temperature, only power-on reset clears it
  always_comb begin
    therm_d = therm_q | I_OVER_TEMP;
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      therm_q <= 1'b0;
    end else begin
      therm_q <= therm_d;
    end
  end

  // sequencer: off, soft-start, run, cool-down
  always_comb begin
    st_d   = st_q;
    tmr_d  = tmr_q;
    step_d = step_q;
    ref_d  = ref_q;
    on_d   = on_q;
    case (st_q)
      fault_prot_pkg::ST_OFF: begin
        on_d  = 1'b0;
        ref_d = fault_prot_pkg::REF_RESET;
        if (I_ENABLE && cfg_taken_q && !therm_q) begin
          st_d   = fault_prot_pkg::ST_SOFT;
          tmr_d  = 32'h0;
          step_d = 32'h0;
          on_d   = 1'b1;
        end
      end
      fault_prot_pkg::ST_SOFT: begin
        tmr_d = tmr_q + 32'h1;
        if (step_q == 32'(STEP_CYCLES - 1)) begin
          step_d = 32'h0;
          if (ref_q != {fault_prot_pkg::REF_W{1'b1}}) begin
            ref_d = ref_q + 8'h01;
          end
        end else begin
          step_d = step_q + 32'h1;
        end
        if (tmr_q == 32'(SS_CYCLES - 1)) begin
          st_d  = fault_prot_pkg::ST_RUN;
          ref_d = {fault_prot_pkg::REF_W{1'b1}};
        end
      end
      fault_prot_pkg::ST_RUN: begin
        on_d = 1'b1;
      end
      fault_prot_pkg::ST_COOL: begin
        on_d  = 1'b0;
        ref_d = fault_prot_pkg::REF_RESET;
        tmr_d = tmr_q + 32'h1;
        if (tmr_q == 32'(SS_CYCLES - 1)) begin
          st_d   = fault_prot_pkg::ST_SOFT;
          tmr_d  = 32'h0;
          step_d = 32'h0;
          on_d   = 1'b1;
        end
      end
      default: begin
        st_d  = fault_prot_pkg::ST_OFF;
        on_d  = 1'b0;
        ref_d = fault_prot_pkg::REF_RESET;
      end
    endcase
    // overflow during soft-start or run: shut both, start cool-down
    if (oc_full && (st_q == fault_prot_pkg::ST_SOFT || st_q == fault_prot_pkg::ST_RUN)) begin
      st_d  = fault_prot_pkg::ST_COOL;
      tmr_d = 32'h0;
      on_d  = 1'b0;
      ref_d = fault_prot_pkg::REF_RESET;
    end
    // loss of enable outside cool-down stops the channels
    if (!I_ENABLE && st_q != fault_prot_pkg::ST_COOL) begin
      st_d  = fault_prot_pkg::ST_OFF;
      on_d  = 1'b0;
      ref_d = fault_prot_pkg::REF_RESET; // reference back to zero so a later start ramps
    end
    // thermal latch overrides everything
    if (therm_d) begin
      st_d  = fault_prot_pkg::ST_OFF;
      on_d  = 1'b0;
      ref_d = fault_prot_pkg::REF_RESET;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_q   <= fault_prot_pkg::ST_OFF;
      tmr_q  <= 32'h0;
      step_q <= 32'h0;
      ref_q  <= fault_prot_pkg::REF_RESET;
      on_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      step_q <= step_d;
      ref_q  <= ref_d;
      on_q   <= on_d;
    end
  end

  // over-voltage hysteresis and output-in-window per channel
  always_comb begin
    ov_d  = ov_q;
    win_d = 2'b00;
    for (int i = 0; i < 2; i++) begin
      fault_prot_pkg::chan_sense_s s;
      s = (i == 0) ? I_SENSE_1 : I_SENSE_2;
      if (s.fb_over_voltage) begin
        ov_d[i] = 1'b1;
      end else if (s.fb_ov_release) begin
        ov_d[i] = 1'b0;
      end
      win_d[i] = (st_d == fault_prot_pkg::ST_RUN) && !ov_d[i];
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ov_q  <= 2'b00;
      win_q <= 2'b00;
    end else begin
      ov_q  <= ov_d;
      win_q <= win_d;
    end
  end

  assign O_CHAN_ON            = on_q;
  assign O_SS_REF             = ref_q;
  assign O_OVER_CURRENT       = oc_q;
  assign O_OUTPUT_IN_WINDOW_1 = win_q[0];
  assign O_OUTPUT_IN_WINDOW_2 = win_q[1];
  assign O_THERMAL_LATCHED    = therm_q;

  // protection checks
  full_shutdown_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (oc_full && on_q) |=> !on_q)
    else $error("overflow did not shut channels down");
  therm_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    therm_q |=> therm_q)
    else $error("thermal latch cleared without reset");
  therm_off_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    therm_q |-> (!on_q && st_q == fault_prot_pkg::ST_OFF))
    else $error("channels active while thermally latched");
  cool_clear_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (st_q != fault_prot_pkg::ST_COOL && st_d == fault_prot_pkg::ST_COOL) |=> oc_count == 4'h0)
    else $error("counter not cleared entering cool-down");
  window_low_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (st_q != fault_prot_pkg::ST_RUN) |-> !(win_q[0] || win_q[1]))
    else $error("output-in-window high outside run");
  ov_drop_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    I_SENSE_1.fb_over_voltage |=> !win_q[0])
    else $error("window stayed high on over-voltage");
  win_two_drop_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    I_SENSE_2.fb_over_voltage |=> !win_q[1])
    else $error("second window stayed high on over-voltage");
  temp_trip_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    I_OVER_TEMP |=> (therm_q && !on_q))
    else $error("over temperature did not latch off");

  // sequencer consistency
  on_state_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    on_q == (st_q == fault_prot_pkg::ST_SOFT || st_q == fault_prot_pkg::ST_RUN))
    else $error("channel enable disagrees with sequencer state");
  ref_off_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (st_q == fault_prot_pkg::ST_OFF || st_q == fault_prot_pkg::ST_COOL) |-> ref_q == 8'h00)
    else $error("reference not zero while channels are off");
  ref_run_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (st_q == fault_prot_pkg::ST_RUN) |-> ref_q == 8'hff)
    else $error("reference not at full scale in run");
  enable_off_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (!I_ENABLE && st_q != fault_prot_pkg::ST_COOL) |=> (!on_q && !(win_q[0] || win_q[1])))
    else $error("channels or windows active without enable");

  // sampling and configuration
  flag_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    !(I_CYCLE && on_q) |=> oc_q == $past(oc_q))
    else $error("over-current flags moved without a sample");
  flag_take_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (I_CYCLE && on_q) |=> oc_q == $past(over_now))
    else $error("over-current flags not taken on a sample");
  cfg_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    cfg_taken_q |=> cfg_q == $past(cfg_q))
    else $error("configuration changed after capture");

  // main scenarios: hiccup, retry, thermal, over-voltage, both channels over

  cover_hiccup: cover property (@(posedge I_MCLK) disable iff (!I_RSTN)
    st_q == fault_prot_pkg::ST_COOL ##1 st_q == fault_prot_pkg::ST_COOL);
  cover_retry: cover property (@(posedge I_MCLK) disable iff (!I_RSTN)
    st_q == fault_prot_pkg::ST_COOL ##1 st_q == fault_prot_pkg::ST_SOFT);
  cover_therm: cover property (@(posedge I_MCLK) disable iff (!I_RSTN) $rose(therm_q));
  cover_window_drop: cover property (@(posedge I_MCLK) disable iff (!I_RSTN)
    st_q == fault_prot_pkg::ST_RUN && $fell(win_q[0]));
  cover_both_over: cover property (@(posedge I_MCLK) disable iff (!I_RSTN)
    I_CYCLE && on_q && over_now == 2'b11);
endmodule // buck_fault_protection_hiccup

/* core/fault_prot_pkg.sv */
// Purpose: constants and carriers for the regulator fault-protection block
// Assumes: one clock at 40 MHz; a switching-cycle strobe marks each sample
// Notes:   time figures are kept in their own unit, cycle counts derive from them
// Functional notes
// - each switching cycle, compare each channel's sampled current with its limit
// - each slave block added to a channel raises its limit by 2A
// - one shared 4-bit counter counts up by one per channel overcurrent
// - both channels overcurrent in one cycle advances the counter by two
// - current back under limit before overflow clears the counter
// - both channels under limit in one cycle clears the counter
// - counter at all ones shuts both channels down together
// - shutdown starts a cool-down as long as soft-start, counter cleared at start
// - end of cool-down starts an ordinary soft-start automatically
// - both outputs started after retry gives output-in-window and normal running
// - overcurrent in retry needs a new overflow; hiccup repeats without limit
// - over-voltage drops output-in-window until voltage falls below release level
// - junction over temperature shuts both channels and sets a latch-off
// - thermal latch clears only by a fresh power-on reset
// - soft-start and cool-down each last a fixed 4 ms, reference stepping up
// - output-in-window held low in shutdown and until that channel finishes soft-start
// - two select inputs decode into one of four power-block configurations
package fault_prot_pkg;
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          SS_TIME_US    = 4000;
  localparam int          SS_CYCLES     = SS_TIME_US * (CLK_HZ / 1_000_000);
  localparam int          CNT_W         = 4;
  localparam logic [3:0]  CNT_RESET     = 4'h0;
  localparam logic [3:0]  CNT_FULL      = 4'hf;
  localparam int          LIM_W         = 5;
  localparam logic [4:0]  LIM_BASE_A    = 5'h02;
  localparam logic [4:0]  LIM_STEP_A    = 5'h02;
  localparam int          REF_W         = 8;
  localparam int          SS_STEPS      = 256;
  localparam int          STEP_CYCLES   = SS_CYCLES / SS_STEPS;
  localparam logic [7:0]  REF_RESET     = 8'h00;

  // per-channel comparator inputs
  typedef struct packed {
    logic [4:0] current_a;
    logic       fb_over_voltage;
    logic       fb_ov_release;
  } chan_sense_s;

  // slave-block count per channel, from the select decode
  typedef struct packed {
    logic [2:0] slaves_a;
    logic [2:0] slaves_b;
  } block_cfg_s;

  typedef enum logic [3:0] {
    ST_OFF      = 4'b0001,
    ST_SOFT     = 4'b0010,
    ST_RUN      = 4'b0100,
    ST_COOL     = 4'b1000
  } prot_state_e;
endpackage

/* core/oc_counter.sv */
// Purpose: shared overcurrent counter for both channels
// Assumes: sample strobe is one cycle wide per switching cycle
// Notes:   clear input from the sequencer wins over counting
`timescale 1ns/100ps
module oc_counter (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_sample,
  input  wire logic [1:0]             i_over,
  input  wire logic                   i_clear,
  output logic [fault_prot_pkg::CNT_W-1:0] o_count,
  output logic                        o_full
);
  logic [fault_prot_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [fault_prot_pkg::CNT_W:0]   sum;

  // next count: up by the number of channels over, clear when both under, saturate
  always_comb begin
    sum   = {1'b0, cnt_q} + {3'h0, i_over[0]} + {3'h0, i_over[1]};
    cnt_d = cnt_q;
    if (i_clear) begin
      cnt_d = fault_prot_pkg::CNT_RESET;
    end else if (i_sample) begin
      if (i_over == 2'b00) begin
        cnt_d = fault_prot_pkg::CNT_RESET;
      end else if (sum[fault_prot_pkg::CNT_W]) begin
        cnt_d = fault_prot_pkg::CNT_FULL; // two steps from 14 still stop at full
      end else begin
        cnt_d = sum[fault_prot_pkg::CNT_W-1:0];
      end
    end
  end

  // counter register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= fault_prot_pkg::CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_count = cnt_q;
  assign o_full  = (cnt_q == fault_prot_pkg::CNT_FULL);

  count_two_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_sample && !i_clear && i_over == 2'b11 && cnt_q < 4'hd) |=> cnt_q == $past(cnt_q) + 4'h2)
    else $error("counter did not advance by two");
  count_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_sample && i_over == 2'b00) |=> cnt_q == 4'h0)
    else $error("counter not cleared with both channels under limit");
  count_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_sample && !i_clear && $onehot(i_over) && cnt_q < 4'hf) |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("counter did not advance by one");
endmodule // oc_counter

/* test/comparator_model.sv */
// Purpose: behavioural current and feedback comparators in front of the protection block
// Assumes: currents in amps, feedback voltage in percent of the reference
// Notes:   over-voltage trips above 115 percent, release reads true below 110 percent
`timescale 1ns/100ps
module comparator_model (
  input  wire logic [4:0]                  i_current_1,
  input  wire logic [4:0]                  i_current_2,
  input  wire logic [7:0]                  i_volt_1,
  input  wire logic [7:0]                  i_volt_2,
  output fault_prot_pkg::chan_sense_s      o_sense_1,
  output fault_prot_pkg::chan_sense_s      o_sense_2
);
  // hysteretic thresholds: between 110 and 115 both flags read low
  always_comb begin
    o_sense_1.current_a       = i_current_1;
    o_sense_1.fb_over_voltage = (i_volt_1 > 8'h73);
    o_sense_1.fb_ov_release   = (i_volt_1 < 8'h6e);
    o_sense_2.current_a       = i_current_2;
    o_sense_2.fb_over_voltage = (i_volt_2 > 8'h73);
    o_sense_2.fb_ov_release   = (i_volt_2 < 8'h6e);
  end
endmodule // comparator_model

/* test/buck_fault_protection_hiccup_tb.sv */
// Purpose: self-checking bench for the overcurrent hiccup, over-voltage and thermal latch
// Assumes: soft-start shortened to 64 cycles, one cycle per reference step
// Notes:   inputs change at the falling edge; channel 1 is select A and bit 0
`timescale 1ns/100ps
module buck_fault_protection_hiccup_tb;
  localparam int SS = 64;
  logic                        mclk  = 1'b0;
  logic                        rstn  = 1'b0;
  logic                        cyc   = 1'b0;
  logic                        en    = 1'b1;
  logic                        hot   = 1'b0;
  logic [1:0]                  sel   = 2'h0;
  logic [4:0]                  cur1  = 5'h00;
  logic [4:0]                  cur2  = 5'h00;
  logic [7:0]                  volt1 = 8'h64;
  logic [7:0]                  volt2 = 8'h64;
  fault_prot_pkg::chan_sense_s s1, s2;
  logic                        chan_on, win1, win2, tlat;
  logic [7:0]                  ref_v;
  logic [1:0]                  oc;
  int                          num_errors = 0;
  int                          cmp_count  = 0;
  int                          cycles     = 0;

  comparator_model comparator_model_i (
    .i_current_1(cur1), .i_current_2(cur2), .i_volt_1(volt1), .i_volt_2(volt2),
    .o_sense_1(s1), .o_sense_2(s2));

  buck_fault_protection_hiccup #(.SS_CYCLES(SS), .STEP_CYCLES(1)) buck_fault_protection_hiccup_i (
    .I_MCLK(mclk), .I_RSTN(rstn), .I_CYCLE(cyc), .I_ENABLE(en),
    .I_CURRENT_CONFIG_SELECT_A(sel[0]), .I_CURRENT_CONFIG_SELECT_B(sel[1]),
    .I_SENSE_1(s1), .I_SENSE_2(s2), .I_OVER_TEMP(hot), .O_CHAN_ON(chan_on),
    .O_SS_REF(ref_v), .O_OVER_CURRENT(oc), .O_OUTPUT_IN_WINDOW_1(win1),
    .O_OUTPUT_IN_WINDOW_2(win2), .O_THERMAL_LATCHED(tlat));

  // clock and hang guard
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // n back-to-back samples with held currents, then one idle cycle
  task automatic sample(input logic [4:0] c1, input logic [4:0] c2, input int n);
    cur1 = c1;
    cur2 = c2;
    cyc  = 1'b1;
    tick(n);
    cyc  = 1'b0;
    tick(1);
  endtask

  function automatic logic pick(input int k);
    return (k == 0) ? chan_on : win1;
  endfunction

  task automatic wait_for(input string what, input int k, input int lo, input int hi);
    int n;
    n = 0;
    while (pick(k) !== 1'b1 && n < hi) begin
      tick(1);
      n++;
    end
    check(what, 8'h01, {7'h00, (pick(k) === 1'b1) && (n >= lo)});
  endtask

  task automatic start_up(input logic [1:0] cfg);
    rstn = 1'b0;
    sel  = cfg;
    tick(4);
    check("on in reset", 8'h00, {7'h00, chan_on});
    check("latch in reset", 8'h00, {7'h00, tlat});
    rstn = 1'b1;
    wait_for("start", 0, 0, 5);
    check("window in soft-start", 8'h00, {7'h00, win1});
    tick(4);
    check("ref ramp", 8'h04, ref_v);
    wait_for("soft-start end", 1, SS - 6, SS);
    check("ref in run", 8'hff, ref_v);
  endtask

  task automatic test_limits();
    int sa[4];
    int sb[4];
    logic [4:0] la, lb;
    sa = '{2, 3, 1, 4};
    sb = '{2, 1, 3, 0};
    for (int k = 0; k < 4; k++) begin
      start_up(2'(k));
      la = 5'(2 + 2 * sa[k]);
      lb = 5'(2 + 2 * sb[k]);
      sample(la, lb + 5'h01, 1);
      check("over flags b", 8'h02, {6'h00, oc});
      sample(la + 5'h01, lb, 1);
      check("over flags a", 8'h01, {6'h00, oc});
      sample(5'h00, 5'h00, 1);
    end
    $display("test limits done");
  endtask

  task automatic test_hiccup();
    start_up(2'h0);
    sample(5'h07, 5'h00, 14);
    tick(2);
    check("on after 14 single", 8'h01, {7'h00, chan_on});
    sample(5'h00, 5'h00, 1);
    sample(5'h07, 5'h07, 7);
    sample(5'h00, 5'h00, 1);
    sample(5'h07, 5'h07, 7);
    tick(2);
    check("on after cleared 14", 8'h01, {7'h00, chan_on});
    sample(5'h07, 5'h07, 1);
    tick(2);
    check("off on overflow", 8'h00, {7'h00, chan_on});
    check("window in shutdown", 8'h00, {7'h00, win1});
    wait_for("cool-down", 0, SS - 4, SS + 8);
    sample(5'h07, 5'h00, 14);
    tick(2);
    check("retry needs overflow", 8'h01, {7'h00, chan_on});
    sample(5'h07, 5'h00, 1);
    tick(2);
    check("retry shutdown", 8'h00, {7'h00, chan_on});
    cur1 = 5'h00;
    wait_for("second cool-down", 0, SS - 4, SS + 8);
    wait_for("retry run", 1, SS - 2, SS + 4);
    $display("test hiccup done");
  endtask

  task automatic test_ov();
    volt1 = 8'h78;
    tick(2);
    check("window over", 8'h02, {6'h00, win2, win1});
    volt1 = 8'h70;
    tick(3);
    check("window hysteresis", 8'h02, {6'h00, win2, win1});
    volt1 = 8'h69;
    tick(2);
    check("window released", 8'h03, {6'h00, win2, win1});
    $display("test ov done");
  endtask

  task automatic test_thermal();
    hot = 1'b1;
    tick(2);
    check("thermal off", 8'h02, {6'h00, tlat, chan_on});
    hot  = 1'b0;
    cur1 = 5'h1f;
    sample(5'h1f, 5'h1f, 8);
    tick(2 * SS + 10);
    check("latched stays off", 8'h02, {6'h00, tlat, chan_on});
    check("ref off", 8'h00, ref_v);
    check("windows off", 8'h00, {6'h00, win2, win1});
    start_up(2'h0);
    $display("test thermal done");
  endtask

  // loss of enable drops channels and windows; enable again runs a full soft-start
  task automatic test_enable();
    en = 1'b0;
    tick(2);
    check("disabled", 8'h00, {5'h00, win2, win1, chan_on});
    en = 1'b1;
    wait_for("re-enable", 0, 0, 5);
    check("window after re-enable", 8'h00, {7'h00, win1});
    wait_for("re-enable run", 1, SS - 2, SS + 4);
    $display("test enable done");
  endtask

  // main sequence
  initial begin
    test_limits();
    test_hiccup();
    test_ov();
    test_enable();
    test_thermal();
    report_and_stop();
  end
endmodule // buck_fault_protection_hiccup_tb
